// [rtl/pc_fetch_seq.sv]
/*
  Program counter and fetch sequencer: phase generator, start-up wait,
  two-stage fetch/execute pipeline, 11-bit PC with branch sources.
  Assumes a synchronous ROM that returns the word at rom_addr_o in the
  same instruction cycle, and an executor that reports flow requests
  on the cycle's last phase.
*/
// Summary of operation
// - System clock splits into four non-overlapping phase strobes.
// - One instruction cycle equals four system clocks with ce_i high.
// - Fetch in one cycle, execute the fetched word in the next.
// - Instructions that change the PC take two instruction cycles.
// - Program counter is 11 bits, addressing 2048 words.
// - PC increments by one after every fetch that loads no target.
// - PC loads targets on jump, low write, call, reset, interrupt, return.
// - Taken skip discards prefetched word and runs a dummy cycle.
// - Power-up or wake with crystal waits 128 clocks before execution.
// - Wake with internal RC oscillator and no crystal waits only 2 clocks.
// - Return stack holds four nested levels.
// - Reset clears PC so execution starts at address zero.
// - Low byte write jumps inside the current 256-word page.
// - Interrupts vector to 004H, 008H and 00CH.
// - Interrupt waits pending while the stack is full.
`timescale 1ns/100ps
module pc_fetch_seq
  import pc_seq_pkg::*;
(
  // Clock, reset, enable
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            ce_i,
  // Power management
  input  wire logic            wake_i,
  input  wire logic            ext_high_freq_crystal_i,
  input  wire logic            int_high_freq_rc_i,
  // Execution unit flow requests (sampled on last phase)
  input  wire logic            jump_i,
  input  wire logic            call_i,
  input  wire logic            ret_i,
  input  wire logic            skip_i,
  input  wire logic            pc_low_byte_wr_i,
  input  wire logic [7:0]      pc_low_byte_i,
  input  wire logic [PC_W-1:0] target_i,
  // Interrupt requests (already enabled/masked)
  input  wire logic            int0_req_i,
  input  wire logic            int1_req_i,
  input  wire logic            tmr_req_i,
  output logic                 int_ack_o,
  output logic [1:0]           int_src_o,
  // Program memory
  output logic [PC_W-1:0]      rom_addr_o,
  input  wire logic [15:0]     rom_data_i,
  // Pipeline status
  output logic [3:0]           phase_o,
  output logic [15:0]          instr_o,
  output logic                 instr_valid_o,
  output logic                 running_o,
  output logic [PC_W-1:0]      pc_o
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [1:0]      ph;
    logic [7:0]      sst;
    logic            run;
    logic [PC_W-1:0] pc;
    logic [15:0]     ir;
    logic            ir_ok;
    logic            ack;
    logic [1:0]      src;
  } st_t;

  st_t st_ff;
  st_t nxt_st;

  logic            last_ph;
  logic            flow_req;
  logic            do_push;
  logic            do_pop;
  logic            stk_full;
  logic [PC_W-1:0] stk_top;
  logic [PC_W-1:0] push_val;
  logic            int_any;
  logic            int_take;
  logic [1:0]      int_sel;
  logic [PC_W-1:0] int_vec;

  function automatic logic [7:0] sst_clks(input int n);
    sst_clks = 8'(n - 1);
  endfunction : sst_clks

  // Fixed priority: first external line, second line, then timer
  function automatic logic [1:0] int_pick(input logic r0, input logic r1);
    int_pick = r0 ? 2'h0 : (r1 ? 2'h1 : 2'h2);
  endfunction : int_pick

  // ****************************************************************
  // Interrupt priority
  // ****************************************************************
  assign int_any = int0_req_i | int1_req_i | tmr_req_i;
  assign int_sel = int_pick(int0_req_i, int1_req_i);

  always_comb begin
    int_vec = TMR_VEC;
    if (int_sel == 2'h0) begin
      int_vec = INT0_VEC;
    end else if (int_sel == 2'h1) begin
      int_vec = INT1_VEC;
    end
  end

  // ****************************************************************
  // Flow requests
  // ****************************************************************
  assign last_ph  = st_ff.run && (st_ff.ph == 2'(PHASES - 1));
  assign flow_req = jump_i || call_i || ret_i || pc_low_byte_wr_i || skip_i;
  // Taken only where the current instruction leaves the PC alone:
  // no request is lost and the pushed PC is a true return point.
  // A return on a full stack frees its level first; the waiting
  // request follows in the dummy cycle after it.
  assign int_take = last_ph && int_any && !stk_full && !flow_req;
  assign do_push  = last_ph && (call_i || int_take);
  assign do_pop   = last_ph && ret_i;
  // Word being fetched is dropped, so the handler returns to it
  assign push_val = st_ff.pc;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    nxt_st     = st_ff;
    nxt_st.ack = 1'b0;
    if (wake_i) begin
      // Halt wake restarts the start-up timer
      nxt_st.run = 1'b0;
      nxt_st.ph  = '0;
      nxt_st.sst = int_high_freq_rc_i && !ext_high_freq_crystal_i
                 ? sst_clks(SST_RC_CLKS)
                 : sst_clks(SST_XTAL_CLKS);
    end else if (!st_ff.run) begin
      if (st_ff.sst == '0) begin
        nxt_st.run = 1'b1;
      end else begin
        nxt_st.sst = st_ff.sst - 8'h01;
      end
    end else begin
      nxt_st.ph = st_ff.ph + 2'h1;
      if (last_ph) begin
        // Default: latch fetched word, advance PC
        nxt_st.ir    = rom_data_i;
        nxt_st.ir_ok = 1'b1;
        nxt_st.pc    = st_ff.pc + 11'h001;
        if (int_take) begin
          // Never alongside a flow request of the current instruction
          nxt_st.pc    = int_vec;
          nxt_st.ir_ok = 1'b0;
          nxt_st.ack   = 1'b1;
          nxt_st.src   = int_sel;
        end else if (jump_i || call_i) begin
          nxt_st.pc    = target_i;
          nxt_st.ir_ok = 1'b0;
        end else if (ret_i) begin
          nxt_st.pc    = stk_top;
          nxt_st.ir_ok = 1'b0;
        end else if (pc_low_byte_wr_i) begin
          nxt_st.pc    = {st_ff.pc[PC_W-1:8], pc_low_byte_i};
          nxt_st.ir_ok = 1'b0;
        end else if (skip_i) begin
          // Fetched word dropped, becomes a dummy cycle
          nxt_st.ir_ok = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff     <= '0;
      st_ff.pc  <= RESET_VEC;
      // Power-up always waits the long crystal period
      st_ff.sst <= sst_clks(SST_XTAL_CLKS);
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Return stack
  // ****************************************************************
  ret_stack #(
    .DEPTH (STACK_DEPTH)
  ) u_stack (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .push_i (do_push),
    .pop_i  (do_pop),
    .data_i (push_val),
    .top_o  (stk_top),
    .full_o (stk_full)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Strobes stay dark through the start-up wait
  always_comb begin
    phase_o = '0;
    if (st_ff.run) begin
      phase_o[st_ff.ph] = 1'b1;
    end
  end

  assign rom_addr_o    = st_ff.pc;
  assign pc_o          = st_ff.pc;
  assign instr_o       = st_ff.ir;
  assign instr_valid_o = st_ff.ir_ok && st_ff.run;
  assign running_o     = st_ff.run;
  assign int_ack_o     = st_ff.ack;
  assign int_src_o     = st_ff.src;
endmodule : pc_fetch_seq

// [rtl/pc_seq_pkg.sv]
/*
  Constants and types for the program counter and fetch sequencer.
  Assumes a single system clock; no software-visible registers.
*/
package pc_seq_pkg;
  // ****************************************************************
  // Widths and vectors
  // ****************************************************************
  localparam int          PC_W          = 11;
  localparam int          STACK_DEPTH   = 4;
  localparam logic [10:0] RESET_VEC     = 11'h000;
  localparam logic [10:0] INT0_VEC      = 11'h004;
  localparam logic [10:0] INT1_VEC      = 11'h008;
  localparam logic [10:0] TMR_VEC       = 11'h00C;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          PHASES        = 4;
  localparam int          SST_XTAL_CLKS = 128;
  localparam int          SST_RC_CLKS   = 2;

  typedef enum logic [1:0] {
    FL_NEXT,
    FL_JUMP,
    FL_CALL,
    FL_RET
  } flow_t;
endpackage : pc_seq_pkg

// [rtl/ret_stack.sv]
/*
  Return-address stack of fixed depth.
  Assumes push and pop are never asserted together.
*/
`timescale 1ns/100ps
module ret_stack
  import pc_seq_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
) (
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            ce_i,
  // Stack operations
  input  wire logic            push_i,
  input  wire logic            pop_i,
  input  wire logic [PC_W-1:0] data_i,
  output logic      [PC_W-1:0] top_o,
  output logic                 full_o
);
  typedef struct packed {
    logic [DEPTH-1:0][PC_W-1:0] mem;
    logic [$clog2(DEPTH+1)-1:0] cnt;
  } stk_t;

  stk_t stk_ff;
  stk_t nxt_stk;

  always_comb begin
    nxt_stk = stk_ff;
    if (push_i) begin
      // Overflow drops the oldest entry by shifting everything down
      nxt_stk.mem = {stk_ff.mem[DEPTH-2:0], data_i};
      if (stk_ff.cnt != DEPTH[$clog2(DEPTH+1)-1:0]) begin
        nxt_stk.cnt = stk_ff.cnt + 1'b1;
      end
    end else if (pop_i) begin
      nxt_stk.mem = {data_i, stk_ff.mem[DEPTH-1:1]};
      if (stk_ff.cnt != '0) begin
        nxt_stk.cnt = stk_ff.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stk_ff <= '0;
    end else if (ce_i) begin
      stk_ff <= nxt_stk;
    end
  end

  assign top_o  = stk_ff.mem[0];
  assign full_o = (stk_ff.cnt == DEPTH[$clog2(DEPTH+1)-1:0]);
endmodule : ret_stack

// [tb/pc_fetch_seq_monitor.sv]
/* Port checker for pc_fetch_seq phases, pipeline and PC loads.
   Assumes one clock domain; bound to every instance. */
`timescale 1ns/100ps
module pc_fetch_seq_monitor
  import pc_seq_pkg::*;
(
  // Clock and inputs
  input wire logic            clk_i,
  input wire logic            rst_i,
  input wire logic            ce_i,
  input wire logic            wake_i,
  input wire logic            jump_i,
  input wire logic            skip_i,
  input wire logic [PC_W-1:0] target_i,
  input wire logic [15:0]     rom_data_i,
  // Outputs
  input wire logic            int_ack_o,
  input wire logic [1:0]      int_src_o,
  input wire logic [3:0]      phase_o,
  input wire logic [15:0]     instr_o,
  input wire logic            instr_valid_o,
  input wire logic            running_o,
  input wire logic [PC_W-1:0] pc_o
);
  // ****************************************
  // Properties
  // ****************************************
  logic go;
  assign go = running_o & ce_i & phase_o[3] & !wake_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_onehot; $onehot0(phase_o) && (phase_o == 4'h0 || running_o); endproperty
  a_onehot: assert property (p_onehot) else $error("phase code");
  property p_rot; running_o && ce_i && !wake_i && phase_o != 4'h0
    |=> phase_o == {$past(phase_o[2:0]), $past(phase_o[3])}; endproperty
  a_rot: assert property (p_rot) else $error("phase order");
  property p_hold; running_o && ce_i && !wake_i && phase_o[2:0] != 3'h0
    |=> $stable(pc_o) && $stable(instr_o); endproperty
  a_hold: assert property (p_hold) else $error("pc moved mid cycle");
  property p_rst; $past(rst_i) |-> pc_o == 11'h000 && phase_o == 4'h0 && !running_o; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_jump; go && jump_i |=> pc_o == $past(target_i) && !instr_valid_o;
  endproperty
  a_jump: assert property (p_jump) else $error("jump load");
  property p_skip; go && skip_i |=> !instr_valid_o; endproperty
  a_skip: assert property (p_skip) else $error("skip dummy");
  property p_seq; go ##1 instr_valid_o
    |-> pc_o == $past(pc_o) + 11'h1 && instr_o == $past(rom_data_i); endproperty
  a_seq: assert property (p_seq) else $error("fetch sequence");
  property p_vec; int_ack_o |-> pc_o == {7'h00, int_src_o + 2'h1, 2'h0}; endproperty
  a_vec: assert property (p_vec) else $error("interrupt vector");
endmodule : pc_fetch_seq_monitor
bind pc_fetch_seq pc_fetch_seq_monitor u_mon (.*);

// [tb/program_counter_fetch_sequencer_tb.sv]
/* Self-checking bench for pc_fetch_seq with a modelled program memory.
   Assumes inputs change 1 ns after each edge; ce_i is low only in its own test. */
`timescale 1ns/100ps
module program_counter_fetch_sequencer_tb;
  import pc_seq_pkg::*;
  logic clk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, wake_i = 1'h0;
  logic ext_high_freq_crystal_i = 1'h1, int_high_freq_rc_i = 1'h0;
  logic jump_i = 1'h0, call_i = 1'h0, ret_i = 1'h0, skip_i = 1'h0, pc_low_byte_wr_i = 1'h0;
  logic int0_req_i = 1'h0, int1_req_i = 1'h0, tmr_req_i = 1'h0, int_ack_o, instr_valid_o;
  logic            running_o;
  logic [7:0]      pc_low_byte_i = 8'h00;
  logic [1:0]      int_src_o;
  logic [3:0]      phase_o;
  logic [15:0]     rom_data_i, instr_o;
  logic [PC_W-1:0] target_i = 11'h000, rom_addr_o, pc_o;
  int              err_total = 0, compares = 0, n;
  // Op, argument, PC after; ops 1 jump 2 call 3 ret 4 skip 5 low byte
  logic [24:0] rows [10] = '{{3'h1, 11'h123, 11'h123}, {3'h0, 11'h000, 11'h124},
    {3'h5, 11'h045, 11'h145}, {3'h0, 11'h000, 11'h146}, {3'h4, 11'h000, 11'h147},
    {3'h0, 11'h000, 11'h148}, {3'h2, 11'h7FF, 11'h7FF}, {3'h0, 11'h000, 11'h000},
    {3'h3, 11'h000, 11'h148}, {3'h0, 11'h000, 11'h149}};
  pc_fetch_seq u_dut (.*);
  rom_model u_rom (.addr_i(rom_addr_o), .data_o(rom_data_i));
  initial forever #4 clk_i = ~clk_i;
  // Run needs under 1000 cycles; 12500 is ample
  initial begin
    #100000;
    err_total++;
    final_report();
  end
  task check(input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task settle(input int exp);
    n = 0;
    while (running_o !== 1'h1 && n < 300) begin
      @(posedge clk_i);
      #1 n++;
    end
    check(16'(n), 16'(exp));
  endtask : settle
  task step(input logic [2:0] op, input logic [10:0] arg, exp_pc, input logic exp_v);
    n = 0;
    while (phase_o !== 4'h8 && n < 20) begin
      @(posedge clk_i);
      #1 n++;
    end
    check(16'(phase_o), 16'h0008);
    {jump_i, call_i, ret_i, skip_i, pc_low_byte_wr_i} = op == 3'h0 ? 5'h00 : 5'h10 >> (op - 3'h1);
    target_i = arg;
    pc_low_byte_i = arg[7:0];
    @(posedge clk_i);
    #1 {jump_i, call_i, ret_i, skip_i, pc_low_byte_wr_i} = 5'h00;
    check(16'(pc_o), 16'(exp_pc));
    check(16'(instr_valid_o), 16'(exp_v));
    if (exp_v) check(instr_o, {5'h15, exp_pc - 11'h1});
  endtask : step
  task final_report;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'h0;
    check(16'(pc_o), 16'h0000);
    settle(SST_XTAL_CLKS);
    $display("startup test done");
    foreach (rows[i]) step(rows[i][24:22], rows[i][21:11], rows[i][10:0], rows[i][24:22] == 3'h0);
    $display("flow table done");
    for (int i = 0; i < 3; i++) begin
      {tmr_req_i, int1_req_i, int0_req_i} = 3'h1 << i;
      step(3'h0, 11'h000, {7'h00, 2'(i + 1), 2'h0}, 1'h0);
      check(16'(int_ack_o), 16'h0001);
      check(16'(int_src_o), 16'(i));
      {tmr_req_i, int1_req_i, int0_req_i} = 3'h0;
    end
    // Fourth level fills the stack, so the next request must wait
    step(3'h2, 11'h300, 11'h300, 1'h0);
    int1_req_i = 1'h1;
    step(3'h0, 11'h000, 11'h301, 1'h1);
    // Return frees a level; the waiting request follows in the dummy cycle
    step(3'h3, 11'h000, 11'h00C, 1'h0);
    step(3'h0, 11'h000, 11'h008, 1'h0);
    check(16'(int_src_o), 16'h0001);
    int1_req_i = 1'h0;
    // Handler returns to the word its entry displaced
    step(3'h3, 11'h000, 11'h00C, 1'h0);
    $display("interrupt test done");
    // Enable low freezes phase and PC
    ce_i = 1'h0;
    repeat (3) @(posedge clk_i);
    #1 check(16'(phase_o), 16'h0001);
    check(16'(pc_o), 16'h000C);
    ce_i = 1'h1;
    $display("enable test done");
    rst_i = 1'h1;
    @(posedge clk_i);
    #1 rst_i = 1'h0;
    check(16'(pc_o), 16'h0000);
    check(16'(running_o), 16'h0000);
    settle(SST_XTAL_CLKS);
    $display("reset test done");
    for (int k = 0; k < 2; k++) begin
      ext_high_freq_crystal_i = k[0];
      int_high_freq_rc_i = 1'h1;
      wake_i = 1'h1;
      @(posedge clk_i);
      #1 wake_i = 1'h0;
      settle(k == 1 ? SST_XTAL_CLKS : SST_RC_CLKS);
    end
    $display("wake test done");
    final_report();
  end
endmodule : program_counter_fetch_sequencer_tb

// [tb/rom_model.sv]
/* Program memory model for the fetch sequencer bench.
   Assumes the address is steady for the cycle it is read in. */
`timescale 1ns/100ps
module rom_model
  import pc_seq_pkg::*;
(
  // Fetch port
  input  wire logic [PC_W-1:0] addr_i,
  output logic      [15:0]     data_o
);
  // Address inside the word lets every fetch be traced
  assign data_o = {5'h15, addr_i};
endmodule : rom_model
